//--- gp_defines.svh
// Offsets, reset values and field positions of the general purpose port block
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// Special function register addresses
`define GP_ADDR_PORT0 8'h80
`define GP_ADDR_PORT2 8'hA0
`define GP_ADDR_P0_DRIVE 8'hA4
`define GP_ADDR_P1_BYPASS 8'hD5
`define GP_ADDR_P0_ANALOG 8'hF1

// Reset values
`define GP_RST_PORT0 8'hFF
`define GP_RST_PORT2 1'b1
`define GP_RST_P0_DRIVE 8'h00
`define GP_RST_P1_BYPASS 7'h00
`define GP_RST_P0_ANALOG 8'hFF

// Field widths and positions
`define GP_P0_WIDTH 8
`define GP_P1_BYPASS_WIDTH 7
`define GP_P2_BIT 0
`define GP_SYNC_WIDTH 9

`endif

//--- gp_pkg.sv
// Types shared by the general purpose port block
package gp_pkg;

	// Processor-side access to the special function registers
	typedef struct packed {
		logic [7:0] addr;
		logic rd;
		logic rmw;
		logic wr;
		logic [7:0] wdata;
		logic bit_wr;
		logic [2:0] bit_idx;
		logic bit_val;
	} gp_sfr_req_s;

	// Crossbar claims and peripheral drive for port 0
	typedef struct packed {
		logic [7:0] own;
		logic [7:0] out;
		logic [7:0] oe;
	} gp_xbar_s;

	// Whole state of the port block
	typedef struct packed {
		logic [7:0] latch0;
		logic latch2;
		logic [7:0] analog0;
		logic [7:0] drive0;
		logic [6:0] bypass1;
		logic [7:0] rdata;
		logic [7:0] p0_out;
		logic [7:0] p0_oe;
		logic p2_out;
		logic p2_oe;
	} gp_state_s;

endpackage : gp_pkg

//--- gp_pin_sync.sv
// Two-stage synchroniser for the port pin levels
`timescale 1ns/100ps
`default_nettype none
`include "gp_defines.svh"

module gp_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Asynchronous pins in, synchronised levels out
	input wire logic [`GP_SYNC_WIDTH-1:0] pin_async,
	output var logic [`GP_SYNC_WIDTH-1:0] pin_sync
);
	logic [`GP_SYNC_WIDTH-1:0] meta_reg;

	// First stage feeds only the second one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			pin_sync <= '0;
		end else if (ce) begin
			meta_reg <= pin_async;
			pin_sync <= meta_reg;
		end
	end
endmodule : gp_pin_sync
`default_nettype wire

//--- gp_port_io.sv
// General purpose port I/O: latches, mode registers, pin read and drive
`timescale 1ns/100ps
`default_nettype none
`include "gp_defines.svh"

// Operation
// - Pins not claimed by crossbar or analog use serve as software I/O.
// - Port registers accept both whole-byte and single-bit access.
// - Port writes go to an output latch that holds the driven level.
// - Plain reads return sampled pin levels, even on crossbar-owned pins.
// - Logic, complement, inc, dec and jump ops are read-modify-write.
// - Bit move, clear and set on a port bit are read-modify-write.
// - Read-modify-write reads the latch, not the pins, then writes back.
// - With the routing matrix disabled every port driver stays off.
module gp_port_io (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Special function register access
	input wire gp_pkg::gp_sfr_req_s sfr,
	output var logic [7:0] sfr_rdata,
	// Crossbar side
	input wire logic routing_matrix_enable,
	input wire gp_pkg::gp_xbar_s xbar,
	output var logic [6:0] port1_bypass,
	// Port 0 pins
	input wire logic [7:0] p0_in,
	output var logic [7:0] p0_out,
	output var logic [7:0] p0_oe,
	// Port 2 pin
	input wire logic p2_in,
	output var logic p2_out,
	output var logic p2_oe
);
	import gp_pkg::*;

	gp_state_s state_reg;
	gp_state_s state_next;
	logic [`GP_SYNC_WIDTH-1:0] pin_sync;
	logic [7:0] p0_level;

	////////////////////////////////////////////////////////////////////////
	// Pin sampling

	// Pins are asynchronous to the core clock
	gp_pin_sync u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.pin_async({p2_in, p0_in}),
		.pin_sync(pin_sync)
	);

	// Analog pins have their receiver off and read low
	assign p0_level = pin_sync[7:0] & state_reg.analog0;

	// Replace one bit of a byte
	function automatic logic [7:0] set_bit(input logic [7:0] v,
		input logic [2:0] idx, input logic b);
		logic [7:0] r;
		r = v;
		r[idx] = b;
		return r;
	endfunction : set_bit

	// Register select
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		return a == t;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Register writes, reads and pin drive
	always_comb begin
		state_next = state_reg;
		// Byte writes; read-modify-write results arrive here too
		if (sfr.wr) begin
			if (hit(sfr.addr, `GP_ADDR_PORT0)) begin
				state_next.latch0 = sfr.wdata;
			end
			if (hit(sfr.addr, `GP_ADDR_PORT2)) begin
				state_next.latch2 = sfr.wdata[`GP_P2_BIT];
			end
			if (hit(sfr.addr, `GP_ADDR_P0_DRIVE)) begin
				state_next.drive0 = sfr.wdata;
			end
			if (hit(sfr.addr, `GP_ADDR_P1_BYPASS)) begin
				state_next.bypass1 = sfr.wdata[`GP_P1_BYPASS_WIDTH-1:0];
			end
			if (hit(sfr.addr, `GP_ADDR_P0_ANALOG)) begin
				state_next.analog0 = sfr.wdata;
			end
		end
		// Bit ops modify the latch, never the pin level
		if (sfr.bit_wr) begin
			if (hit(sfr.addr, `GP_ADDR_PORT0)) begin
				state_next.latch0 = set_bit(state_reg.latch0, sfr.bit_idx,
					sfr.bit_val);
			end
			if (hit(sfr.addr, `GP_ADDR_PORT2) &&
				sfr.bit_idx == 3'(`GP_P2_BIT)) begin
				state_next.latch2 = sfr.bit_val;
			end
		end
		// Read data: latch for port modify cycles, pins for plain port reads, mode registers as stored
		if (sfr.rd) begin
			state_next.rdata = 8'h00;
			unique case (sfr.addr)
				`GP_ADDR_PORT0: state_next.rdata = sfr.rmw ?
					state_reg.latch0 : p0_level;
				`GP_ADDR_PORT2: state_next.rdata[`GP_P2_BIT] = sfr.rmw ?
					state_reg.latch2 : pin_sync[8];
				`GP_ADDR_P0_DRIVE: state_next.rdata = state_reg.drive0;
				`GP_ADDR_P1_BYPASS: state_next.rdata = {1'b0,
					state_reg.bypass1};
				`GP_ADDR_P0_ANALOG: state_next.rdata = state_reg.analog0;
				default: state_next.rdata = 8'h00;
			endcase
		end
		// Drive: peripheral owns claimed pins, latch drives the rest
		for (int i = 0; i < `GP_P0_WIDTH; i++) begin
			state_next.p0_out[i] = xbar.own[i] ? xbar.out[i] :
				state_next.latch0[i];
			// Open-drain only ever pulls low
			state_next.p0_oe[i] = routing_matrix_enable &&
				state_next.analog0[i] && (xbar.own[i] ? xbar.oe[i] &&
				(state_next.drive0[i] || !xbar.out[i]) :
				(state_next.drive0[i] || !state_next.latch0[i]));
		end
		// Port 2 pin is digital and open-drain
		state_next.p2_out = state_next.latch2;
		state_next.p2_oe = routing_matrix_enable &&
			!state_next.latch2;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Clock enable freezes everything
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.latch0 <= `GP_RST_PORT0;
			state_reg.latch2 <= `GP_RST_PORT2;
			state_reg.analog0 <= `GP_RST_P0_ANALOG;
			state_reg.drive0 <= `GP_RST_P0_DRIVE;
			state_reg.bypass1 <= `GP_RST_P1_BYPASS;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state flops
	assign sfr_rdata = state_reg.rdata;
	assign port1_bypass = state_reg.bypass1;
	assign p0_out = state_reg.p0_out;
	assign p0_oe = state_reg.p0_oe;
	assign p2_out = state_reg.p2_out;
	assign p2_oe = state_reg.p2_oe;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Drive checks are only evaluated in cycles with ce high, not while state is frozen
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_latch_byte_write: assert property (
		ce && sfr.wr && !sfr.bit_wr && sfr.addr == `GP_ADDR_PORT0
		|=> state_reg.latch0 == $past(sfr.wdata))
		else $error("port0 latch missed byte write");
	a_pin_level_read: assert property (
		ce && sfr.rd && !sfr.rmw && sfr.addr == `GP_ADDR_PORT0
		|=> sfr_rdata == $past(pin_sync[7:0] & state_reg.analog0))
		else $error("port0 read did not return pins");
	a_rmw_latch_read: assert property (
		ce && sfr.rd && sfr.rmw && sfr.addr == `GP_ADDR_PORT0
		|=> sfr_rdata == $past(state_reg.latch0))
		else $error("modify read did not return latch");
	a_bit_set_clear: assert property (
		ce && sfr.bit_wr && !sfr.wr && sfr.addr == `GP_ADDR_PORT0
		|=> state_reg.latch0[$past(sfr.bit_idx)] == $past(sfr.bit_val))
		else $error("port0 bit op lost");
	a_port2_bit_op: assert property (
		ce && sfr.bit_wr && !sfr.wr && sfr.addr == `GP_ADDR_PORT2 &&
		sfr.bit_idx == 3'h0 |=> p2_out == $past(sfr.bit_val))
		else $error("port2 bit op not driven");
	a_port2_pin_read: assert property (
		ce && sfr.rd && !sfr.rmw && sfr.addr == `GP_ADDR_PORT2
		|=> sfr_rdata == {7'h00, $past(pin_sync[8])})
		else $error("port2 read did not return pin");
	a_bit_op_refused: assert property (
		ce && sfr.bit_wr && !sfr.wr && sfr.addr == `GP_ADDR_P0_DRIVE
		|=> state_reg.drive0 == $past(state_reg.drive0))
		else $error("bit op changed a byte-only register");
	a_xbar_off_drive: assert property (
		ce && !routing_matrix_enable |=> p0_oe == 8'h00 && !p2_oe)
		else $error("driver on with routing disabled");
	a_analog_no_drive: assert property (
		ce |=> (p0_oe & ~state_reg.analog0) == 8'h00)
		else $error("analog pin driven");
	a_open_drain_high: assert property (
		ce |=> (p0_oe & p0_out & ~state_reg.drive0) == 8'h00)
		else $error("open-drain pin driven high");
	a_gpio_follows: assert property (
		ce && !sfr.wr && !sfr.bit_wr |=>
		((p0_out ^ state_reg.latch0) & ~$past(xbar.own)) == 8'h00)
		else $error("free pin not driven from latch");

	c_byte_write: cover property (ce && sfr.wr &&
		sfr.addr == `GP_ADDR_PORT0);
	c_rmw_read: cover property (ce && sfr.rd && sfr.rmw &&
		sfr.addr == `GP_ADDR_PORT0 ##1 ce && sfr.wr);
	c_bit_write: cover property (ce && sfr.bit_wr &&
		sfr.addr == `GP_ADDR_PORT2);
	c_push_pull: cover property (p0_oe[0] && p0_out[0]);

endmodule : gp_port_io
`default_nettype wire

//--- gp_ext_pins.sv
// External circuitry on the port pins: pull-ups and commanded low pulls
`timescale 1ns/100ps
`default_nettype none
module gp_ext_pins (
	// Device drive
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p0_oe,
	input wire logic p2_out,
	input wire logic p2_oe,
	// Low pulls commanded by the bench
	input wire logic [7:0] pull_lo,
	// Resolved levels
	output var logic [7:0] p0_in,
	output var logic p2_in
);
	// Released pins sit at the pull-up unless pulled low
	assign p0_in = (p0_oe & p0_out) | (~p0_oe & ~pull_lo);
	assign p2_in = p2_oe ? p2_out : 1'b1;
endmodule : gp_ext_pins
`default_nettype wire

//--- general_purpose_port_io_test.sv
// Self-checking bench for the general purpose port block
`timescale 1ns/100ps
`default_nettype none
module general_purpose_port_io_test;
	import gp_pkg::*;
	logic clk, reset_n, ce, rme, p2_in, p2_out, p2_oe;
	gp_sfr_req_s sfr;
	gp_xbar_s xbar;
	logic [7:0] rdata, p0_out, p0_oe, p0_in, pull_lo, v;
	logic [6:0] byp;
	logic [7:0] q[$];
	logic [31:0] seed;
	int n_fail, checks;
	gp_port_io i_gp_port_io (.clk(clk), .reset_n(reset_n), .ce(ce),
		.sfr(sfr), .sfr_rdata(rdata), .routing_matrix_enable(rme),
		.xbar(xbar), .port1_bypass(byp), .p0_in(p0_in), .p0_out(p0_out),
		.p0_oe(p0_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe));
	gp_ext_pins i_gp_ext_pins (.p0_out(p0_out), .p0_oe(p0_oe),
		.p2_out(p2_out), .p2_oe(p2_oe), .pull_lo(pull_lo), .p0_in(p0_in),
		.p2_in(p2_in));
	////////////////////////////////////////////////////////////////////////
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// Xorshift step for the random latch and pin patterns
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xorshift
	// Kind bits: rd, rmw, wr, bit_wr; bit op takes val/idx from d[3:0]
	task automatic op(input logic [7:0] a, input logic [3:0] k,
		input logic [7:0] d);
		gp_sfr_req_s r;
		r = '0;
		{r.rd, r.rmw, r.wr, r.bit_wr} = k;
		r.addr = a;
		r.wdata = d;
		{r.bit_val, r.bit_idx} = d[3:0];
		@(negedge clk);
		sfr = r;
		@(negedge clk);
		sfr = '0;
	endtask : op
	task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
		q.push_back(e);
		op(a, {1'b1, m, 2'b00}, 8'h00);
	endtask : rd
	// Core-style modify cycle: latch read, write back in the next cycle
	task automatic rmw_xor(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		gp_sfr_req_s r;
		r = '0;
		r.addr = a;
		{r.rd, r.rmw} = 2'b11;
		q.push_back(e);
		@(negedge clk);
		sfr = r;
		@(negedge clk);
		r = '0;
		r.addr = a;
		r.wr = 1'b1;
		r.wdata = rdata ^ m;
		sfr = r;
		@(negedge clk);
		sfr = '0;
	endtask : rmw_xor
	task automatic print_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// Each taken read shows its data once the edge has landed
	always @(posedge clk) begin
		if (sfr.rd && ce) begin
			#1;
			cmp(rdata, q.pop_front());
		end
	end
	// Hang guard at 2000 cycles, well past the roughly 125 cycles needed
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset_n, rme, pull_lo} = '0;
		ce = 1'b1;
		sfr = '0;
		xbar = '0;
		seed = 32'h10a4;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		rd(8'h80, 1, 8'hFF);
		rd(8'hA0, 1, 8'h01);
		rd(8'hA4, 0, 8'h00);
		rd(8'hD5, 0, 8'h00);
		rd(8'hF1, 0, 8'hFF);
		rd(8'h90, 0, 8'h00);
		op(8'hA4, 4'b0010, 8'hFF);
		seed = xorshift(seed);
		v = seed[7:0];
		op(8'h80, 4'b0010, v);
		cmp(p0_oe, 8'h00);
		rme = 1'b1;
		@(negedge clk);
		cmp(p0_out, v);
		cmp(p0_oe, 8'hFF);
		op(8'hA4, 4'b0010, 8'h00);
		cmp(p0_oe, ~v);
		repeat (2) @(negedge clk);
		rd(8'h80, 0, v);
		op(8'h80, 4'b0010, 8'hFF);
		pull_lo = seed[15:8];
		repeat (2) @(negedge clk);
		rd(8'h80, 0, ~seed[15:8]);
		rd(8'h80, 1, 8'hFF);
		pull_lo = '0;
		for (int i = 0; i < 8; i++) begin
			op(8'h80, 4'b0001, 8'(i));
			rd(8'h80, 1, 8'hFF << (i + 1));
		end
		op(8'hA4, 4'b0001, 8'h0F);
		rd(8'hA4, 0, 8'h00);
		op(8'hF1, 4'b0010, 8'h0F);
		cmp(p0_oe, 8'h0F);
		op(8'h80, 4'b0010, 8'hFF);
		repeat (2) @(negedge clk);
		rd(8'h80, 0, 8'h0F);
		op(8'hF1, 4'b0010, 8'hFF);
		op(8'hA4, 4'b0010, 8'hFF);
		xbar = {8'hFF, seed[23:16], 8'hFF};
		@(negedge clk);
		cmp(p0_out, seed[23:16]);
		repeat (2) @(negedge clk);
		rd(8'h80, 0, seed[23:16]);
		rd(8'h80, 1, 8'hFF);
		xbar = '0;
		rme = 1'b0;
		@(negedge clk);
		cmp(p0_oe, 8'h00);
		rme = 1'b1;
		op(8'hD5, 4'b0010, 8'hFF);
		rd(8'hD5, 0, 8'h7F);
		cmp({1'b0, byp}, 8'h7F);
		op(8'hA0, 4'b0010, 8'h00);
		cmp({6'h00, p2_oe, p2_out}, 8'h02);
		rd(8'hA0, 1, 8'h00);
		op(8'hA0, 4'b0001, 8'h08);
		rd(8'hA0, 1, 8'h01);
		repeat (2) @(negedge clk);
		rd(8'hA0, 0, 8'h01);
		ce = 1'b0;
		op(8'h80, 4'b0010, 8'h00);
		ce = 1'b1;
		rd(8'h80, 1, 8'hFF);
		rmw_xor(8'h80, v, 8'hFF);
		cmp(p0_out, ~v);
		rd(8'h80, 1, ~v);
		repeat (2) @(negedge clk);
		print_verdict();
	end
endmodule : general_purpose_port_io_test
`default_nettype wire
